// ---- core/gtpc_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "gtpc_consts.svh"

module gtpc_timer (
    input wire logic clock,
    input wire logic rst,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timer pin, bidirectional
    input wire logic timer_pin_i,
    output logic timer_pin_o,
    output logic timer_pin_oe,
    // Sibling timer links
    input wire logic sync_start_in,
    output logic sync_start_out,
    input wire logic sync_clear_in,
    output logic sync_clear_out,
    output logic adc_trigger
);
    ////////////////////////////////////////////////////////////////////
    // Registers and bus handshake
    logic [15:0] ctrl_q;
    logic count_enable_bit_q;
    logic [15:0] compare_a_value_q;
    logic [15:0] compare_b_period_q;
    logic [15:0] count_value_q;
    logic [15:0] presc_q;
    logic [15:0] capt_q;
    logic [4:0] status_q;
    logic [7:0] awaddr_q;
    logic aw_held_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_held_q;
    logic wr_go;
    logic [15:0] wval;

    gtpc_pkg::gtpc_mode_t mode;
    gtpc_pkg::gtpc_clr_t clr_sel;
    assign mode = gtpc_pkg::gtpc_mode_t'(ctrl_q[`GTPC_CTRL_MODE_LO +: 2]);
    assign clr_sel = gtpc_pkg::gtpc_clr_t'(ctrl_q[`GTPC_CTRL_CLR_LO +: 2]);

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            awaddr_q <= 8'h00;
        end else if (wr_go) begin
            aw_held_q <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            w_held_q <= 1'b0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else if (wr_go) begin
            w_held_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end
    end

    assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q[7:2] > `GTPC_OFS_PRESC >> 2) ? 2'h2 : 2'h0;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    logic wr_ctrl, wr_cmd, wr_a, wr_b, wr_cnt, wr_presc;
    assign wval = wdata_q[15:0];
    assign wr_ctrl = wr_go && awaddr_q[7:2] == `GTPC_OFS_CTRL >> 2;
    assign wr_cmd = wr_go && awaddr_q[7:2] == `GTPC_OFS_CMD >> 2;
    assign wr_a = wr_go && awaddr_q[7:2] == `GTPC_OFS_CMPA >> 2;
    assign wr_b = wr_go && awaddr_q[7:2] == `GTPC_OFS_CMPB >> 2;
    assign wr_cnt = wr_go && awaddr_q[7:2] == `GTPC_OFS_COUNT >> 2;
    assign wr_presc = wr_go && awaddr_q[7:2] == `GTPC_OFS_PRESC >> 2;

    logic timer_clear_cmd;
    assign timer_clear_cmd = wr_cmd && wstrb_q[0] && wdata_q[`GTPC_CMD_CLR];

    ////////////////////////////////////////////////////////////////////
    // Read channel
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            unique case (s_axi_araddr[7:2])
                `GTPC_OFS_CTRL >> 2: s_axi_rdata <= {16'h0000, ctrl_q};
                `GTPC_OFS_CMD >> 2: s_axi_rdata <= {31'h00000000, count_enable_bit_q};
                `GTPC_OFS_CMPA >> 2: s_axi_rdata <= {16'h0000, compare_a_value_q};
                `GTPC_OFS_CMPB >> 2: s_axi_rdata <= {16'h0000, compare_b_period_q};
                `GTPC_OFS_COUNT >> 2: s_axi_rdata <= {16'h0000, count_value_q};
                `GTPC_OFS_STATUS >> 2: s_axi_rdata <= {27'h0000000, status_q};
                `GTPC_OFS_CAPT >> 2: s_axi_rdata <= {16'h0000, capt_q};
                `GTPC_OFS_PRESC >> 2: s_axi_rdata <= {16'h0000, presc_q};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control registers; only reset returns them to reset values, the clear command leaves them
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_q <= 16'h0000;
        end else if (wr_ctrl) begin
            ctrl_q <= merge16(ctrl_q, wdata_q, wstrb_q);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            compare_a_value_q <= 16'h0000;
            compare_b_period_q <= 16'h0000;
            presc_q <= `GTPC_PRESC_RST;
        end else begin
            if (wr_a) compare_a_value_q <= merge16(compare_a_value_q, wdata_q, wstrb_q);
            if (wr_b) compare_b_period_q <= merge16(compare_b_period_q, wdata_q, wstrb_q);
            if (wr_presc) presc_q <= merge16(presc_q, wdata_q, wstrb_q);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Compare buffers
    logic [15:0] compare_buffer_zero, compare_buffer_one;
    logic match_b;
    logic update_always_bit;
    logic load_a, load_b;
    assign update_always_bit = ctrl_q[`GTPC_CTRL_UAO];
    // Without update-always the new values wait for a period boundary: no glitched PWM
    assign load_a = (!update_always_bit && (timer_clear_cmd || match_b)) || (update_always_bit && wr_a);
    assign load_b = (!update_always_bit && (timer_clear_cmd || match_b)) || (update_always_bit && wr_b);

    // Register write lands next edge; buffer copies after that
    logic load_a_q, load_b_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            load_a_q <= 1'b0;
            load_b_q <= 1'b0;
        end else begin
            load_a_q <= load_a;
            load_b_q <= load_b;
        end
    end

    gtpc_cmp_buf u_buf (
        .clock(clock),
        .rst(rst),
        .load_a(load_a_q),
        .load_b(load_b_q),
        .data_a(compare_a_value_q),
        .data_b(compare_b_period_q),
        .buf_zero(compare_buffer_zero),
        .buf_one(compare_buffer_one)
    );

    ////////////////////////////////////////////////////////////////////
    // Prescaler: one-cycle tick every presc_q+1 clocks
    logic [15:0] div_q;
    logic tick;
    assign tick = (div_q == presc_q);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            div_q <= 16'h0000;
        end else if (timer_clear_cmd || tick || !count_enable_bit_q) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Enable and start linking
    logic start_req;
    logic en_cmd;
    assign en_cmd = wr_cmd && wstrb_q[0] && wdata_q[`GTPC_CMD_EN];
    // Unlinked timers ignore sibling start pulses
    assign start_req = en_cmd || (ctrl_q[`GTPC_CTRL_START_LINK_BIT] && sync_start_in);

    gtpc_pkg::gtpc_state_t state_q;
    logic running;
    assign running = state_q == gtpc_pkg::GTPC_RUN;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_enable_bit_q <= 1'b0;
        end else if (timer_clear_cmd) begin
            count_enable_bit_q <= 1'b0;
        end else if (wr_cmd && wstrb_q[0]) begin
            count_enable_bit_q <= wdata_q[`GTPC_CMD_EN];
        end else if (start_req) begin
            count_enable_bit_q <= 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync_start_out <= 1'b0;
        end else begin
            sync_start_out <= en_cmd && ctrl_q[`GTPC_CTRL_START_LINK_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Counter
    logic pin_s1_q, pin_s2_q, pin_s3_q;
    logic cap_rise, cap_fall, cap_edge, cap_clear;
    logic clr_in_s1_q, clr_in_q;
    logic match_a;
    logic last_tick;
    logic ext_clear;
    // Compare in buffer terms: period of B ticks, count 0..B-1
    assign last_tick = (count_value_q == compare_buffer_one - 16'h0001);
    assign match_b = running && tick && mode != gtpc_pkg::GTPC_CAPTURE && last_tick;
    assign match_a = running && tick && mode != gtpc_pkg::GTPC_CAPTURE
                     && compare_buffer_zero != 16'h0000
                     && count_value_q == compare_buffer_zero - 16'h0001;
    assign ext_clear = ctrl_q[`GTPC_CTRL_CLEAR_LINK_BIT] && clr_in_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clr_in_s1_q <= 1'b0;
            clr_in_q <= 1'b0;
        end else begin
            clr_in_s1_q <= sync_clear_in;
            clr_in_q <= clr_in_s1_q;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync_clear_out <= 1'b0;
        end else begin
            sync_clear_out <= match_b && ctrl_q[`GTPC_CTRL_CLEAR_LINK_BIT];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= gtpc_pkg::GTPC_IDLE;
        end else if (timer_clear_cmd || !count_enable_bit_q) begin
            state_q <= gtpc_pkg::GTPC_IDLE;
        end else begin
            unique case (state_q)
                gtpc_pkg::GTPC_IDLE: begin
                    // Zero period cannot start, except in capture mode
                    if (compare_buffer_one != 16'h0000 || mode == gtpc_pkg::GTPC_CAPTURE) begin
                        state_q <= gtpc_pkg::GTPC_RUN;
                    end
                end
                gtpc_pkg::GTPC_RUN: begin
                    if (match_b && mode == gtpc_pkg::GTPC_ONESHOT) begin
                        state_q <= gtpc_pkg::GTPC_DONE;
                    end
                end
                gtpc_pkg::GTPC_DONE: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_value_q <= 16'h0000;
        end else if (timer_clear_cmd) begin
            count_value_q <= 16'h0000;
        end else if (wr_cnt) begin
            count_value_q <= merge16(count_value_q, wdata_q, wstrb_q);
        end else if (cap_clear || (running && ext_clear)) begin
            count_value_q <= 16'h0000;
        end else if (match_b) begin
            count_value_q <= 16'h0000;
        end else if (running && tick) begin
            count_value_q <= count_value_q + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Capture: sync pin, edges delayed to the fixed capture point
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
        end else begin
            pin_s1_q <= timer_pin_i;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // Edge seen 3 cycles after pin; two more stages reach 5
    logic [1:0] rise_d_q, fall_d_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rise_d_q <= 2'h0;
            fall_d_q <= 2'h0;
        end else begin
            rise_d_q <= {rise_d_q[0], pin_s2_q && !pin_s3_q};
            fall_d_q <= {fall_d_q[0], !pin_s2_q && pin_s3_q};
        end
    end
    assign cap_rise = running && mode == gtpc_pkg::GTPC_CAPTURE && rise_d_q[1];
    assign cap_fall = running && mode == gtpc_pkg::GTPC_CAPTURE && fall_d_q[1];
    assign cap_edge = cap_rise || cap_fall;
    assign cap_clear = (cap_rise && (clr_sel == gtpc_pkg::GTPC_CLR_RISE
                                     || clr_sel == gtpc_pkg::GTPC_CLR_BOTH))
                    || (cap_fall && (clr_sel == gtpc_pkg::GTPC_CLR_FALL
                                     || clr_sel == gtpc_pkg::GTPC_CLR_BOTH));

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            capt_q <= 16'h0000;
        end else if (timer_clear_cmd) begin
            capt_q <= 16'h0000;
        end else if (cap_edge) begin
            capt_q <= count_value_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status: hardware set wins over write-one-to-clear
    logic ovf;
    assign ovf = running && tick && count_value_q == 16'hffff && !match_b;
    logic [4:0] st_set;
    assign st_set = {1'b0, cap_edge, ovf, match_b, match_a};
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            status_q <= 5'h00;
        end else if (timer_clear_cmd) begin
            status_q <= 5'h00;
        end else begin
            status_q[3:0] <= st_set[3:0] | (status_q[3:0]
                & ~((wr_go && awaddr_q[7:2] == `GTPC_OFS_STATUS >> 2) ? wdata_q[3:0] : 4'h0));
            status_q[`GTPC_ST_RUN] <= running;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin output
    logic lvl;
    logic start_edge;
    logic running_q;
    assign lvl = ctrl_q[`GTPC_CTRL_LVL];
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            running_q <= 1'b0;
        end else begin
            running_q <= running;
        end
    end
    assign start_edge = running && !running_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            timer_pin_o <= 1'b0;
            timer_pin_oe <= 1'b0;
        end else begin
            timer_pin_oe <= mode != gtpc_pkg::GTPC_CAPTURE;
            if (timer_clear_cmd || state_q == gtpc_pkg::GTPC_IDLE) begin
                timer_pin_o <= lvl;
            end else if (mode == gtpc_pkg::GTPC_PERIODIC) begin
                if (start_edge && compare_buffer_zero == compare_buffer_one) begin
                    timer_pin_o <= !timer_pin_o;
                end else if (match_a && compare_buffer_zero != compare_buffer_one) begin
                    timer_pin_o <= !timer_pin_o;
                end
            end else if (state_q == gtpc_pkg::GTPC_DONE) begin
                timer_pin_o <= !lvl;
            end else if (mode != gtpc_pkg::GTPC_CAPTURE) begin
                // Active level from start of period until match A
                if (match_b) begin
                    // One-shot must not show a stray active cycle before it stops
                    timer_pin_o <= (mode == gtpc_pkg::GTPC_PWM) ? lvl : !lvl;
                end else if (match_a) begin
                    timer_pin_o <= !lvl;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // ADC trigger, self-clearing
    logic [1:0] trig_cnt_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            trig_cnt_q <= 2'h0;
            adc_trigger <= 1'b0;
        end else if (match_a && mode == gtpc_pkg::GTPC_PWM && ctrl_q[`GTPC_CTRL_ADCEN]) begin
            trig_cnt_q <= `GTPC_TRIG_LEN;
            adc_trigger <= 1'b1;
        end else if (trig_cnt_q != 2'h0) begin
            trig_cnt_q <= trig_cnt_q - 2'h1;
            adc_trigger <= trig_cnt_q != 2'h1;
        end
    end
endmodule : gtpc_timer
`default_nettype wire

// ---- core/gtpc_consts.svh ----
// Behaviour
// - Count on prescaled timer reference clock enable
// - Period equals compare-B value in ticks
// - Match-A event at compare-A value
// - Clear command resets state, loads both buffers unless update-always is set
// - No start while compare-B is zero, except in capture mode
// - Without update-always, buffers reload on clear or B match
// - Update-always loads buffers on every write
// - Periodic mode toggles pin on match A
// - Compare-A zero holds pin level
// - A equal B toggles at count start
// - Initial pin level from initial-level bit
// - One-shot gives single PWM-shaped pulse
// - PWM period from B, width from A
// - PWM mode triggers ADC at match A
// - Start-linked timers start together
// - Clear-linked timers clear on shorter period
// - Unlinked timers run independently
// - Capture on pin edges, five cycles late
// - Clear-select field picks counter clear edge
// - ADC trigger drops after three cycles
// - Readable and writable 16-bit counter
// - Overflow flag only on FFFF to zero
`ifndef GTPC_CONSTS_SVH
`define GTPC_CONSTS_SVH

`define GTPC_OFS_CTRL 8'h00
`define GTPC_OFS_CMD 8'h04
`define GTPC_OFS_CMPA 8'h08
`define GTPC_OFS_CMPB 8'h0c
`define GTPC_OFS_COUNT 8'h10
`define GTPC_OFS_STATUS 8'h14
`define GTPC_OFS_CAPT 8'h18
`define GTPC_OFS_PRESC 8'h1c

`define GTPC_CTRL_MODE_LO 0
`define GTPC_CTRL_UAO 2
`define GTPC_CTRL_LVL 3
`define GTPC_CTRL_START_LINK_BIT 4
`define GTPC_CTRL_CLEAR_LINK_BIT 5
`define GTPC_CTRL_CLR_LO 6
`define GTPC_CTRL_ADCEN 8

`define GTPC_CMD_EN 0
`define GTPC_CMD_CLR 1

`define GTPC_ST_MATCHA 0
`define GTPC_ST_MATCHB 1
`define GTPC_ST_OVF 2
`define GTPC_ST_CAPT 3
`define GTPC_ST_RUN 4

`define GTPC_CAPT_DELAY 3'h5
`define GTPC_TRIG_LEN 2'h3
`define GTPC_PRESC_RST 16'h0000

`endif

// ---- core/gtpc_pkg.sv ----
package gtpc_pkg;
    typedef enum logic [1:0] {
        GTPC_PERIODIC,
        GTPC_ONESHOT,
        GTPC_PWM,
        GTPC_CAPTURE
    } gtpc_mode_t;

    typedef enum logic [1:0] {
        GTPC_CLR_NONE,
        GTPC_CLR_RISE,
        GTPC_CLR_FALL,
        GTPC_CLR_BOTH
    } gtpc_clr_t;

    typedef enum logic [1:0] {
        GTPC_IDLE,
        GTPC_RUN,
        GTPC_DONE
    } gtpc_state_t;
endpackage : gtpc_pkg

// ---- core/gtpc_cmp_buf.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "gtpc_consts.svh"

// Two-word compare buffer; read data registered
module gtpc_cmp_buf (
    input wire logic clock,
    input wire logic rst,
    input wire logic load_a,
    input wire logic load_b,
    input wire logic [15:0] data_a,
    input wire logic [15:0] data_b,
    output logic [15:0] buf_zero,
    output logic [15:0] buf_one
);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            buf_zero <= 16'h0000;
        end else if (load_a) begin
            buf_zero <= data_a;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            buf_one <= 16'h0000;
        end else if (load_b) begin
            buf_one <= data_b;
        end
    end
endmodule : gtpc_cmp_buf
`default_nettype wire

// ---- verif/gtpc_timer_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module gtpc_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic sync_start_out,
    input wire logic sync_clear_out,
    input wire logic adc_trigger
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence trig_burst;
        adc_trigger [*3] ##1 !adc_trigger;
    endsequence
    a_trig_len: assert property ($rose(adc_trigger) |-> trig_burst)
        else $error("adc trigger width wrong");
    a_start_pulse: assert property (sync_start_out |=> !sync_start_out)
        else $error("start link pulse too long");
    a_clear_pulse: assert property (sync_clear_out |=> !sync_clear_out)
        else $error("clear link pulse too long");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule : gtpc_chk
`default_nettype wire

// ---- verif/gtpc_pin_far.sv ----
`timescale 1ns/1ps
`default_nettype none
module gtpc_pin_far #(
    parameter int CONV_CYCLES = 6
) (
    input wire logic clock,
    input wire logic pin_o,
    input wire logic pin_oe,
    input wire logic level,
    input wire logic adc_trigger,
    output logic pin_i,
    output int trig_seen,
    output int overruns
);
    logic trig_q = 1'h0;
    int busy = 0;
    // Device wins the wire while it drives
    assign pin_i = pin_oe ? pin_o : level;
    initial begin
        trig_seen = 0;
        overruns = 0;
    end
    always @(posedge clock) begin
        trig_q <= adc_trigger;
        if (busy > 0) busy <= busy - 1;
        if (adc_trigger && !trig_q) begin
            trig_seen <= trig_seen + 1;
            if (busy > 0) overruns <= overruns + 1;
            busy <= CONV_CYCLES;
        end
    end
endmodule : gtpc_pin_far
`default_nettype wire

// ---- verif/tb_general_timer_pwm_capture.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_general_timer_pwm_capture;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, lvl = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, p;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic ssi = 1'h0;
    logic timer_pin_i, timer_pin_o, timer_pin_oe, sync_start_out, sync_clear_out, adc_trigger;
    int fails = 0, checked = 0, trigs, overruns, n, m;
    always #12.5 clock = ~clock;
    gtpc_timer dut (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_pin_i, .timer_pin_o, .timer_pin_oe,
        .sync_start_in(ssi), .sync_start_out, .sync_clear_in(1'h0), .sync_clear_out,
        .adc_trigger);
    gtpc_pin_far far (.clock, .pin_o(timer_pin_o), .pin_oe(timer_pin_oe), .level(lvl),
        .adc_trigger, .pin_i(timer_pin_i), .trig_seen(trigs), .overruns);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        if (fails == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic tmo(input int k);
        if (k >= 200) begin
            fails++;
            finish_test();
        end
    endtask : tmo
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (k = 0; k < 200; k++) begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h0;
        tmo(k);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int k;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (k = 0; k < 200; k++) begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        tmo(k);
    endtask : rd
    // Cycles until the pin level changes
    task automatic gap(output int c);
        logic o;
        o = timer_pin_o;
        for (c = 1; c < 200; c++) begin
            @(posedge clock);
            if (timer_pin_o !== o) break;
        end
        tmo(c);
    endtask : gap
    task automatic go(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
        wr(8'h08, a);
        wr(8'h0c, b);
        wr(8'h00, c);
        wr(8'h04, 32'h2);
        wr(8'h04, 32'h1);
    endtask : go
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'h0;
        repeat (2) @(posedge clock);
        rd(8'h00);
        chk("ctrl", 32'h0, v);
        rd(8'h20);
        chk("unmapped", 32'h2, r);
        wr(8'h10, 32'h1234);
        rd(8'h10);
        chk("count", 32'h1234, v);
        go(32'h3, 32'h0, 32'h0);
        repeat (20) @(posedge clock);
        rd(8'h14);
        chk("run b zero", 32'h0, v[4]);
        go(32'h3, 32'h8, 32'h0);
        gap(n);
        gap(n);
        chk("toggle period", 32'h8, n);
        wr(8'h08, 32'h0);
        // New A reaches the buffer at the next B match; no toggle follows it
        repeat (20) @(posedge clock);
        p = timer_pin_o;
        repeat (40) @(posedge clock);
        chk("pin held", p, timer_pin_o);
        go(32'h4, 32'ha, 32'h10a);
        gap(n);
        gap(n);
        gap(m);
        @(negedge clock);
        chk("pwm period", 32'ha, n + m);
        chk("pwm width", 32'h4, timer_pin_o ? n : m);
        chk("adc trig", 32'h1, trigs > 0);
        go(32'h4, 32'ha, 32'h9);
        repeat (40) @(posedge clock);
        rd(8'h14);
        chk("one shot run", 32'h0, v[4]);
        chk("one shot pin", 32'h0, timer_pin_o);
        go(32'h4, 32'ha, 32'h3);
        lvl <= 1'h1;
        repeat (20) @(posedge clock);
        rd(8'h14);
        chk("capture flag", 32'h1, v[3]);
        chk("adc overrun", 32'h0, overruns);
        // Sibling start pulse: ignored without the start link, obeyed with it
        for (n = 0; n < 2; n++) begin
            wr(8'h00, n ? 32'h10 : 32'h0);
            wr(8'h04, 32'h2);
            ssi <= 1'h1;
            @(posedge clock);
            ssi <= 1'h0;
            repeat (4) @(posedge clock);
            rd(8'h14);
            chk("linked start", n, v[4]);
        end
        wr(8'h04, 32'h1);
        repeat (4) @(posedge clock);
        finish_test();
    end
endmodule : tb_general_timer_pwm_capture
`default_nettype wire
bind gtpc_timer gtpc_chk u_chk (.clock, .rst, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .sync_start_out, .sync_clear_out, .adc_trigger);
